// ===== dsl_pkg.sv
/*
  Constants for the debug security lock: register addresses, field
  positions, reset values, unlock code and probe access target classes.
  Assumes a 32-bit word register port on the system clock.
*/
package dsl_pkg;

  localparam int unsigned DSL_DATA_W = 32;
  localparam int unsigned DSL_ADDR_W = 32;

  // Register byte addresses
  localparam logic [DSL_ADDR_W-1:0] DSL_SECURITY_MODE_ADDR = 32'hffffe510;
  localparam logic [DSL_ADDR_W-1:0] DSL_SECURITY_CTRL_ADDR = 32'hffffe514;

  // Security mode register layout
  localparam int unsigned            DSL_SEC_ON_BIT   = 0;
  localparam logic                   DSL_SEC_ON_RESET = 1'h1;
  localparam logic [DSL_DATA_W-1:0]  DSL_READ_ZERO    = 32'h00000000;

  // Unlock code for the security control register
  localparam logic [DSL_DATA_W-1:0]  DSL_UNLOCK_CODE  = 32'h000000c5;

  // Probe access target classes
  localparam int unsigned DSL_TGT_W = 3;
  typedef enum logic [DSL_TGT_W-1:0] {
    DSL_TGT_CORE   = 3'h0,
    DSL_TGT_RAM    = 3'h1,
    DSL_TGT_EXTDEV = 3'h2,
    DSL_TGT_ROM    = 3'h3,
    DSL_TGT_PERIPH = 3'h4
  } dsl_target_type;

  // Lock states, Gray coded along secured -> armed -> open
  typedef enum logic [1:0] {
    DSL_ST_SECURED = 2'h0,
    DSL_ST_ARMED   = 2'h1,
    DSL_ST_OPEN    = 2'h3
  } dsl_state_type;

endpackage

// ===== dsl_probe_gate.sv
/*
  Probe access filter: decides, per registered probe request, whether it
  may pass to the system. Assumes request signals already synchronised
  to mclk_i and the unlocked level coming from the lock's own flip-flop.
*/
`timescale 1ns/10ps
module dsl_probe_gate
  import dsl_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  input  wire logic           unlocked_i,
  input  wire logic           req_i,
  input  wire logic           we_i,
  input  wire dsl_target_type tgt_i,
  output logic                grant_o,
  output logic                deny_o
);

  logic allowed;
  logic grant_r;
  logic deny_r;

  // ROM never readable; writes only to core, memory, external devices
  assign allowed = unlocked_i &&
                   (we_i ? (tgt_i == DSL_TGT_CORE || tgt_i == DSL_TGT_RAM ||
                            tgt_i == DSL_TGT_EXTDEV)
                         : (tgt_i != DSL_TGT_ROM));

  // One-cycle verdict per request
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end else begin
      grant_r <= req_i && allowed;
      deny_r  <= req_i && !allowed;
    end
  end

  assign grant_o = grant_r;
  assign deny_o  = deny_r;

endmodule

// ===== dsl_debug_security_lock.sv
/*
  Debug security lock top: register port for the security mode and
  security control registers, lock state machine, and the filter that
  gates every access from the debug support unit probe.
  Assumes a one-cycle strobe register master on mclk_i and probe request
  pins that are asynchronous to mclk_i.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module dsl_debug_security_lock
  import dsl_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  // Register port
  input  wire logic [DSL_ADDR_W-1:0] addr_i,
  input  wire logic [DSL_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [DSL_DATA_W-1:0] rdata_o,
  // Debug support unit probe pins
  input  wire logic                  probe_req_i,
  input  wire logic                  probe_we_i,
  input  wire logic [DSL_TGT_W-1:0]  probe_tgt_i,
  output logic                       probe_grant_o,
  output logic                       probe_deny_o,
  // Lock status
  output logic                       debug_enabled_o
);

  // Two-flop synchronisers for probe pins
  logic [DSL_TGT_W+1:0] probe_meta_r;
  logic [DSL_TGT_W+1:0] probe_sync_r;
  logic                 probe_req_d_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      probe_meta_r  <= '0;
      probe_sync_r  <= '0;
      probe_req_d_r <= 1'b0;
    end else begin
      probe_meta_r  <= {probe_req_i, probe_we_i, probe_tgt_i};
      probe_sync_r  <= probe_meta_r;
      probe_req_d_r <= probe_sync_r[DSL_TGT_W+1];
    end
  end

  // One request per rising edge of the request level
  logic           probe_req_pulse;
  logic           probe_we_s;
  dsl_target_type probe_tgt_s;
  assign probe_req_pulse = probe_sync_r[DSL_TGT_W+1] && !probe_req_d_r;
  assign probe_we_s      = probe_sync_r[DSL_TGT_W];
  assign probe_tgt_s     = dsl_target_type'(probe_sync_r[DSL_TGT_W-1:0]);

  // Register decode; software is trusted to use word accesses
  logic sel_mode;
  logic sel_ctrl;
  logic wr_mode;
  logic wr_ctrl;
  logic code_ok;
  assign sel_mode = (addr_i == DSL_SECURITY_MODE_ADDR);
  assign sel_ctrl = (addr_i == DSL_SECURITY_CTRL_ADDR);
  assign wr_mode  = wr_i && sel_mode;
  assign wr_ctrl  = wr_i && sel_ctrl;
  assign code_ok  = (wdata_i == DSL_UNLOCK_CODE);

  // Lock state machine
  dsl_state_type state_r;
  dsl_state_type state_nxt;
  logic          sec_on_r;
  logic          sec_on_nxt;

  // Security-on flag follows software writes
  assign sec_on_nxt = wr_mode ? wdata_i[DSL_SEC_ON_BIT] : sec_on_r;

  // Armed once the flag is clear; open only on code write while armed
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DSL_ST_SECURED: begin
        if (!sec_on_nxt) begin
          state_nxt = DSL_ST_ARMED;
        end
      end
      DSL_ST_ARMED: begin
        if (sec_on_nxt) begin
          state_nxt = DSL_ST_SECURED;
        end else if (wr_ctrl && code_ok && !sec_on_r) begin
          state_nxt = DSL_ST_OPEN;
        end
      end
      DSL_ST_OPEN: begin
        // Setting the flag again re-secures the probe path
        if (sec_on_nxt) begin
          state_nxt = DSL_ST_SECURED;
        end
      end
      default: begin
        state_nxt = DSL_ST_SECURED;
      end
    endcase
  end
  // Wrong code or flag still set: no transition above

  // Lock registers; reset always re-secures
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r  <= DSL_ST_SECURED;
      sec_on_r <= DSL_SEC_ON_RESET;
    end else begin
      state_r  <= state_nxt;
      sec_on_r <= sec_on_nxt;
    end
  end

  // Read path; control register is write-only and reads zero
  logic [DSL_DATA_W-1:0] rdata_nxt;
  logic [DSL_DATA_W-1:0] rdata_r;
  assign rdata_nxt = (rd_i && sel_mode)
                     ? {{(DSL_DATA_W-1){1'b0}}, sec_on_r}
                     : DSL_READ_ZERO;

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_r <= DSL_READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Registered unlock level feeds the filter and status pin
  logic debug_en_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      debug_en_r <= 1'b0;
    end else begin
      debug_en_r <= (state_nxt == DSL_ST_OPEN);
    end
  end

  // Probe filter; its pins reach only the probe path
  dsl_probe_gate u_gate (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .unlocked_i (debug_en_r),
    .req_i      (probe_req_pulse),
    .we_i       (probe_we_s),
    .tgt_i      (probe_tgt_s),
    .grant_o    (probe_grant_o),
    .deny_o     (probe_deny_o)
  );

  assign rdata_o         = rdata_r;
  assign debug_enabled_o = debug_en_r;

endmodule

// ===== dsl_debug_security_lock_properties.sv
/*
  Checker for the debug security lock top: register port, lock level and probe answers.
  Assumes it is bound to dsl_debug_security_lock and sees only its ports.
*/
`timescale 1ns/10ps
module dsl_lock_properties
  import dsl_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  rst_n_i,
  input wire logic [DSL_ADDR_W-1:0] addr_i,
  input wire logic [DSL_DATA_W-1:0] wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [DSL_DATA_W-1:0] rdata_o,
  input wire logic                  probe_we_i,
  input wire logic [DSL_TGT_W-1:0]  probe_tgt_i,
  input wire logic                  probe_grant_o,
  input wire logic                  probe_deny_o,
  input wire logic                  debug_enabled_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Unlock steps: flag clear, then the code
  sequence clear_s;
    wr_i && addr_i == DSL_SECURITY_MODE_ADDR && !wdata_i[0];
  endsequence
  sequence code_s;
    wr_i && addr_i == DSL_SECURITY_CTRL_ADDR && wdata_i == DSL_UNLOCK_CODE;
  endsequence
  unlock_seq_a: assert property (clear_s ##1 code_s |=> debug_enabled_o)
    else $error("lock not open after unlock steps");
  open_by_code_a: assert property ($rose(debug_enabled_o) |-> $past(wr_i && addr_i == DSL_SECURITY_CTRL_ADDR && wdata_i == DSL_UNLOCK_CODE))
    else $error("lock opened without code write");
  re_secure_a: assert property (wr_i && addr_i == DSL_SECURITY_MODE_ADDR && wdata_i[0] |=> !debug_enabled_o)
    else $error("lock still open after flag set");
  grant_open_a: assert property (probe_grant_o |-> $past(debug_enabled_o))
    else $error("probe granted while secured");
  probe_filter_a: assert property (probe_grant_o |-> (probe_we_i ? probe_tgt_i < 3'h3 : probe_tgt_i != 3'h3))
    else $error("probe granted to a barred target");
  one_answer_a: assert property (!(probe_grant_o && probe_deny_o))
    else $error("grant and deny together");
  mode_read_a: assert property ($past(rd_i && addr_i == DSL_SECURITY_MODE_ADDR) |-> rdata_o[31:1] == 31'h0)
    else $error("mode read upper bits not zero");
  reset_lock_a: assert property (@(posedge mclk_i) disable iff (1'b0) !rst_n_i |=> !debug_enabled_o)
    else $error("lock open after reset");
endmodule
bind dsl_debug_security_lock dsl_lock_properties i_dsl_lock_properties (.*);

// ===== dsl_probe_model.sv
/*
  Debug probe model: raises one request at a time and reads the answer.
  Assumes the lock's clock and its one-cycle grant and deny pulses.
*/
`timescale 1ns/10ps
module dsl_probe_model
  import dsl_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 grant_i,
  input  wire logic                 deny_i,
  output logic                      req_o = 1'b0,
  output logic                      we_o = 1'b0,
  output logic      [DSL_TGT_W-1:0] tgt_o = 3'h0
);
  // Qualifiers held with the request; the grant or deny pulse stands
  // only between the third and fourth edges after the rise
  task automatic access(input logic we, input logic [DSL_TGT_W-1:0] tgt, output logic [1:0] ans);
    @(posedge mclk_i);
    req_o <= 1'b1;
    we_o <= we;
    tgt_o <= tgt;
    repeat (3) @(posedge mclk_i);
    #1 ans = {grant_i, deny_i};
    @(posedge mclk_i);
    req_o <= 1'b0;
    we_o <= ~we; // Released lines must not keep the last value
    tgt_o <= ~tgt;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule

// ===== dsl_debug_security_lock_tb.sv
/*
  Self-checking bench for the debug security lock.
  Assumes the probe model and the bound checker compile alongside.
*/
`timescale 1ns/10ps
module dsl_debug_security_lock_tb
  import dsl_pkg::*;
;
  logic                  mclk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic [DSL_ADDR_W-1:0] addr_i = 32'h0;
  logic [DSL_DATA_W-1:0] wdata_i = 32'h0;
  logic                  wr_i = 1'b0;
  logic                  rd_i = 1'b0;
  logic [DSL_DATA_W-1:0] rdata_o;
  logic                  probe_req_i;
  logic                  probe_we_i;
  logic [DSL_TGT_W-1:0]  probe_tgt_i;
  logic                  probe_grant_o;
  logic                  probe_deny_o;
  logic                  debug_enabled_o;
  int                    n_fail = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  always #5 mclk_i = ~mclk_i;
  dsl_debug_security_lock i_dsl_debug_security_lock (.*);
  dsl_probe_model i_dsl_probe_model (.mclk_i(mclk_i), .grant_i(probe_grant_o),
    .deny_i(probe_deny_o), .req_o(probe_req_i), .we_o(probe_we_i), .tgt_o(probe_tgt_i));
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write strobe stays up so writes may follow back to back
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask
  task automatic settle(input logic e);
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk("enabled", {31'h0, e}, {31'h0, debug_enabled_o});
  endtask
  task automatic pr(input logic we, input logic [2:0] t, input logic g);
    logic [1:0] ans;
    i_dsl_probe_model.access(we, t, ans);
    chk("probe", {30'h0, g, ~g}, {30'h0, ans});
  endtask
  task automatic t_reset_state();
    rd(DSL_SECURITY_MODE_ADDR, 32'h1);
    rd(DSL_SECURITY_CTRL_ADDR, 32'h0);
    rd(32'hffffe518, 32'h0);
    pr(1'b0, 3'h0, 1'b0);
  endtask
  task automatic t_unlock();
    wr(DSL_SECURITY_CTRL_ADDR, DSL_UNLOCK_CODE);
    settle(1'b0);
    wr(DSL_SECURITY_MODE_ADDR, 32'h0);
    wr(DSL_SECURITY_CTRL_ADDR, 32'h000000c4);
    settle(1'b0);
    rd(DSL_SECURITY_MODE_ADDR, 32'h0);
    wr(DSL_SECURITY_MODE_ADDR, 32'h0);
    wr(DSL_SECURITY_CTRL_ADDR, DSL_UNLOCK_CODE);
    settle(1'b1);
  endtask
  // Every target class, read and write, while open
  task automatic t_probe();
    for (int i = 0; i < 10; i++) begin
      pr(i[0], i[3:1], i[0] ? i[3:1] < 3 : i[3:1] != 3);
    end
  endtask
  task automatic t_resecure();
    wr(DSL_SECURITY_MODE_ADDR, 32'h1);
    settle(1'b0);
    t_unlock();
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    settle(1'b0);
    t_reset_state();
  endtask
  // Hang guard well above the expected run length
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset_state();
    t_unlock();
    t_probe();
    t_resecure();
    print_verdict();
  end
endmodule
